/* File: design/clm_pkg.sv */
// Purpose: Shared constants and carrier types for the cache line maintenance unit.
// Assumes: 32-bit addresses, 8 pointer registers, 32-byte lines.
// Notes: Notes follow.
package clm_pkg;
   localparam int ADDR_W = 32;
   localparam int PTR_SEL_W = 3;
   localparam int LINE_BYTES = 32;
   localparam int OFS_W = $clog2(LINE_BYTES);
   localparam logic [ADDR_W-1:0] LINE_STEP = 32'h0000_0020;
   localparam logic [OFS_W-1:0] OFS_ZERO = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;

   // Operation codes presented by the core.
   typedef enum logic [1:0] {
      CLM_OP_PREFETCH = 2'h0,
      CLM_OP_WRBACK = 2'h1,
      CLM_OP_WRBACK_INV = 2'h2,
      CLM_OP_CODE_INV = 2'h3
   } clm_op_t;

   // One maintenance request from the issue stage.
   typedef struct packed {
      clm_op_t op;
      logic [PTR_SEL_W-1:0] ptr_sel;
      logic post_inc;
      logic parallel;
   } clm_req_t;

   // Line lookup answer returned by the data cache tags.
   typedef struct packed {
      logic hit;
      logic dirty;
   } clm_tag_t;

   // Command sent to the caches and memory side.
   typedef struct packed {
      logic fill;
      logic wrback;
      logic clean;
      logic d_inval;
      logic i_inval;
      logic [ADDR_W-1:0] line_addr;
   } clm_cmd_t;

   // Controller states.
   typedef enum logic [2:0] {
      CLM_ST_IDLE = 3'h0,
      CLM_ST_LOOK = 3'h1,
      CLM_ST_WB = 3'h2,
      CLM_ST_WB_WAIT = 3'h3,
      CLM_ST_DONE = 3'h4
   } clm_state_t;
endpackage

/* File: design/clm_line_addr.sv */
// Purpose: Line address and post-increment arithmetic for one pointer value.
// Assumes: Pointer values are byte addresses.
// Notes: Purely combinational helper used by the controller.
`timescale 1ns/1ps
module clm_line_addr (
   input wire logic [clm_pkg::ADDR_W-1:0] ptr_val,
   output logic [clm_pkg::ADDR_W-1:0] line_addr,
   output logic [clm_pkg::ADDR_W-1:0] ptr_next
);
   import clm_pkg::*;

   // Clearing the offset bits makes every access cover the whole line.
   always_comb begin
      line_addr = {ptr_val[ADDR_W-1:OFS_W], OFS_ZERO};
      ptr_next = ptr_val + LINE_STEP;
   end
endmodule

/* File: design/clm_ctrl.sv */
// Purpose: Executes prefetch, write-back, write-back-invalidate and code invalidate.
// Assumes: Core stalls while busy; caches answer tag lookups in one cycle.
// Notes: Protection lookup is external and arrives with the tag answer.
// Notes: Requests that arrive while busy are ignored; the core must wait for done.
`timescale 1ns/1ps
module clm_ctrl (
   input wire logic mclk,
   input wire logic srst,
   input wire logic req_valid,
   input wire clm_pkg::clm_req_t req,
   input wire logic [clm_pkg::ADDR_W-1:0] ptr_val,
   input wire clm_pkg::clm_tag_t dtag,
   input wire logic region_cacheable_bit,
   input wire logic prot_viol,
   input wire logic fill_busy,
   input wire logic wb_done,
   output logic busy,
   output logic done,
   output logic nop_done,
   output logic illegal_par,
   output logic ptr_we,
   output logic [clm_pkg::PTR_SEL_W-1:0] ptr_wsel,
   output logic [clm_pkg::ADDR_W-1:0] ptr_wdata,
   output clm_pkg::clm_cmd_t cmd
);
   import clm_pkg::*;

   // Controller state; idle is the only state in which a request is taken.
   clm_state_t state_ff, nxt_state;
   // Copy of the accepted request, held until the operation retires.
   // The core may change its request lines once it sees busy, so nothing reads req later.
   clm_req_t req_ff, nxt_req;
   // Captured line address of the operation in flight.
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   // Incremented pointer value captured with the request.
   // Capturing it early means the pointer input may move while the operation runs.
   logic [ADDR_W-1:0] incr_ff, nxt_incr;
   // High from the cycle after acceptance until the finish pulse.
   logic busy_ff, nxt_busy;
   // One-cycle pulse that marks the end of any operation.
   logic done_ff, nxt_done;
   // One-cycle pulse that marks an operation that did nothing.
   logic nop_ff, nxt_nop;
   // One-cycle pulse that marks a refused parallel request.
   logic ill_ff, nxt_ill;
   // Pointer write strobe, raised once per post-incrementing operation.
   logic ptr_we_ff, nxt_ptr_we;
   // Pointer register number and value; both hold until the next write.
   logic [PTR_SEL_W-1:0] wsel_ff, nxt_wsel;
   logic [ADDR_W-1:0] wdata_ff, nxt_wdata;
   // Command to the caches and memory; the flags are one-cycle pulses.
   clm_cmd_t cmd_ff, nxt_cmd;
   // Combinational helper outputs.
   logic [ADDR_W-1:0] line_addr_c;
   logic [ADDR_W-1:0] ptr_next_c;

   // Line address and incremented pointer are formed from the live pointer value.
   // They are only captured on the accepting edge, so later changes do no harm.
   clm_line_addr u_addr (
      .ptr_val(ptr_val),
      .line_addr(line_addr_c),
      .ptr_next(ptr_next_c)
   );

   // Next-state logic; every command flag is a one-cycle pulse.
   // Pulses are built here and registered below, so every output is a flop.
   always_comb begin
      // Everything holds by default; the pulses fall back to zero.
      nxt_state = state_ff;
      nxt_req = req_ff;
      nxt_addr = addr_ff;
      nxt_incr = incr_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_nop = 1'b0;
      nxt_ill = 1'b0;
      nxt_ptr_we = 1'b0;
      nxt_wsel = wsel_ff;
      nxt_wdata = wdata_ff;
      // The command always carries the captured line address.
      nxt_cmd = '0;
      nxt_cmd.line_addr = addr_ff;
      // Each state decides its own pulses below.
      case (state_ff)
         CLM_ST_IDLE: begin
            // Waiting for the core; the request lines are only looked at here.
            // A request bundled with a parallel slot is refused outright.
            if (req_valid && req.parallel) begin
               // Nothing else happens: no lookup, no command and no pointer update.
               nxt_ill = 1'b1;
            end else if (req_valid) begin
               // Capture everything now so the core may release its lines.
               nxt_req = req;
               nxt_addr = line_addr_c;
               nxt_incr = ptr_next_c;
               // Busy rises on the next edge and tells the core to hold off.
               nxt_busy = 1'b1;
               nxt_state = CLM_ST_LOOK;
            end
         end
         CLM_ST_LOOK: begin
            // Tag, region and protection answers are valid in this cycle only.
            // Most outcomes retire directly; only a dirty write-back waits.
            nxt_state = CLM_ST_DONE;
            // A protection violation silently drops the operation; no fault is raised.
            if (prot_viol) begin
               nxt_nop = 1'b1;
            end else begin
               case (req_ff.op)
                  CLM_OP_PREFETCH: begin
                     // A fill is only started for an absent line in a cacheable region.
                     // A fill already running wins; a second one is not queued.
                     if (!dtag.hit && region_cacheable_bit && !fill_busy) begin
                        nxt_cmd.fill = 1'b1;
                     end else begin
                        nxt_nop = 1'b1;
                     end
                  end
                  CLM_OP_WRBACK, CLM_OP_WRBACK_INV: begin
                     // A dirty line is written out first, whichever of the two it is.
                     if (dtag.hit && dtag.dirty) begin
                        nxt_cmd.wrback = 1'b1;
                        nxt_state = CLM_ST_WB_WAIT;
                     end else if (dtag.hit && req_ff.op == CLM_OP_WRBACK_INV) begin
                        // A clean held line is simply dropped by the invalidating form.
                        nxt_cmd.d_inval = 1'b1;
                     end else begin
                        // A miss, or a clean line for the plain form, leaves the cache alone.
                        nxt_nop = 1'b1;
                     end
                  end
                  CLM_OP_CODE_INV: begin
                     // Code lines keep no dirty state, so no write-back is ever issued.
                     nxt_cmd.i_inval = 1'b1;
                  end
                  default: begin
                     // Unreachable with a two-bit code; kept so every path is defined.
                     nxt_nop = 1'b1;
                  end
               endcase
            end
         end
         CLM_ST_WB_WAIT: begin
            // The line state changes only once memory has taken the whole line.
            // Memory may take any number of cycles; there is no time limit here.
            // A limitation: a memory that never answers leaves the unit busy.
            if (wb_done) begin
               // The invalidating form drops the line instead of marking it clean.
               if (req_ff.op == CLM_OP_WRBACK_INV) begin
                  nxt_cmd.d_inval = 1'b1;
               end else begin
                  nxt_cmd.clean = 1'b1;
               end
               nxt_state = CLM_ST_DONE;
            end
         end
         CLM_ST_DONE: begin
            // Pointer update happens for every outcome, no-ops included.
            // The old pointer plus one line is written, and the finish pulse leaves with it.
            if (req_ff.post_inc) begin
               nxt_ptr_we = 1'b1;
               nxt_wsel = req_ff.ptr_sel;
               nxt_wdata = incr_ff;
            end
            nxt_done = 1'b1;
            nxt_busy = 1'b0;
            nxt_state = CLM_ST_IDLE;
         end
         default: begin
            // An unknown state returns to idle and drops the operation.
            nxt_state = CLM_ST_IDLE;
            nxt_busy = 1'b0;
         end
      endcase
   end

   // State registers; reset clears everything to idle.
   // Reset is synchronous, so every register sees it on a clock edge.
   // An operation cut by reset is lost; the core must issue it again.
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_ff <= CLM_ST_IDLE;
         req_ff <= '0;
         addr_ff <= ADDR_ZERO;
         incr_ff <= ADDR_ZERO;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         nop_ff <= 1'b0;
         ill_ff <= 1'b0;
         ptr_we_ff <= 1'b0;
         wsel_ff <= '0;
         wdata_ff <= ADDR_ZERO;
         cmd_ff <= '0;
      end else begin
         // Outside reset every register simply takes its next value.
         state_ff <= nxt_state;
         req_ff <= nxt_req;
         addr_ff <= nxt_addr;
         incr_ff <= nxt_incr;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         nop_ff <= nxt_nop;
         ill_ff <= nxt_ill;
         ptr_we_ff <= nxt_ptr_we;
         wsel_ff <= nxt_wsel;
         wdata_ff <= nxt_wdata;
         cmd_ff <= nxt_cmd;
      end
   end

   // Outputs come straight from the registers above.
   // Busy level and status pulses for the issue stage.
   assign busy = busy_ff;
   assign done = done_ff;
   assign nop_done = nop_ff;
   assign illegal_par = ill_ff;
   // Pointer register write port.
   assign ptr_we = ptr_we_ff;
   assign ptr_wsel = wsel_ff;
   assign ptr_wdata = wdata_ff;
   // Command bundle to the caches and memory side.
   assign cmd = cmd_ff;
endmodule

/* File: testbench/clm_chk.sv */
// Purpose: Port checker for the cache line maintenance controller.
// Assumes: The look cycle follows the taking edge.
// Notes: Bound to every clm_ctrl instance.
`timescale 1ns/1ps
module clm_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic req_valid,
   input wire clm_pkg::clm_req_t req,
   input wire logic [clm_pkg::ADDR_W-1:0] ptr_val,
   input wire clm_pkg::clm_tag_t dtag,
   input wire logic region_cacheable_bit,
   input wire logic prot_viol,
   input wire logic fill_busy,
   input wire logic wb_done,
   input wire logic busy,
   input wire logic done,
   input wire logic nop_done,
   input wire logic illegal_par,
   input wire logic ptr_we,
   input wire logic [clm_pkg::ADDR_W-1:0] ptr_wdata,
   input wire clm_pkg::clm_cmd_t cmd
);
   import clm_pkg::*;
   logic take;
   logic [ADDR_W-1:0] cap_ff, nxt_cap;
   logic wbp_ff, nxt_wbp;
   assign take = req_valid && !busy && !req.parallel;
   // Keep the pointer of the running operation and whether a write-back is open.
   always_comb begin
      nxt_cap = take ? ptr_val : cap_ff;
      nxt_wbp = !srst && (cmd.wrback || (wbp_ff && !done));
   end
   always_ff @(posedge mclk) begin
      cap_ff <= nxt_cap;
      wbp_ff <= nxt_wbp;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   par_refuse_a: assert property (req_valid && !busy && req.parallel |=>
      illegal_par && !busy)
      else $error("parallel request was not refused");
   one_outcome_a: assert property (take |=> busy ##1
      $onehot({cmd.fill, cmd.wrback, cmd.d_inval, cmd.i_inval, nop_done}))
      else $error("operation did not give exactly one outcome");
   line_sel_a: assert property (cmd.fill || cmd.wrback || cmd.d_inval || cmd.i_inval |->
      cmd.line_addr == {cap_ff[ADDR_W-1:OFS_W], OFS_ZERO})
      else $error("line address does not match pointer");
   pf_fill_a: assert property (take && req.op == CLM_OP_PREFETCH ##1 (!dtag.hit &&
      region_cacheable_bit && !fill_busy && !prot_viol) |=> cmd.fill)
      else $error("prefetch miss did not fill");
   pf_skip_a: assert property (take && req.op == CLM_OP_PREFETCH ##1
      (dtag.hit || fill_busy) |=> nop_done && !cmd.fill)
      else $error("prefetch on hit or busy fill was not idle");
   prot_nop_a: assert property (take ##1 prot_viol |=> nop_done ##1 done)
      else $error("protection violation did not become idle");
   code_inv_a: assert property (take && req.op == CLM_OP_CODE_INV ##1 !prot_viol |=>
      cmd.i_inval && !cmd.wrback ##1 done)
      else $error("code invalidate misbehaved");
   wb_end_a: assert property (wbp_ff && $rose(wb_done) |=>
      (cmd.clean ^ cmd.d_inval) ##1 done)
      else $error("write-back did not finish in time");
   ptr_inc_a: assert property (ptr_we |-> done && ptr_wdata == cap_ff + LINE_STEP)
      else $error("pointer update value wrong");
   fill_c: cover property (cmd.fill);
   wb_c: cover property (wbp_ff && $rose(wb_done));
   inc_c: cover property (ptr_we);
endmodule

bind clm_ctrl clm_chk u_chk (
   .mclk(mclk),
   .srst(srst),
   .req_valid(req_valid),
   .req(req),
   .ptr_val(ptr_val),
   .dtag(dtag),
   .region_cacheable_bit(region_cacheable_bit),
   .prot_viol(prot_viol),
   .fill_busy(fill_busy),
   .wb_done(wb_done),
   .busy(busy),
   .done(done),
   .nop_done(nop_done),
   .illegal_par(illegal_par),
   .ptr_we(ptr_we),
   .ptr_wdata(ptr_wdata),
   .cmd(cmd)
);

/* File: testbench/clm_mem_model.sv */
// Purpose: Next memory level answering line write-backs.
// Assumes: The write-back request is a one-cycle pulse.
// Notes: Completion holds until the unit reacts, after a bench-set lag.
`timescale 1ns/1ps
module clm_mem_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic wr_req,
   input wire logic wr_ack,
   input wire logic [3:0] lag,
   output logic wb_done
);
   logic [3:0] cnt_ff, nxt_cnt;
   logic on_ff, nxt_on;
   // Count the latency; a small lag is prompt, a large one is slow.
   always_comb begin
      nxt_on = (on_ff || wr_req) && !wr_ack && !srst;
      nxt_cnt = on_ff ? cnt_ff + 4'h1 : 4'h0;
   end
   always_ff @(posedge mclk) begin
      on_ff <= nxt_on;
      cnt_ff <= nxt_cnt;
   end
   assign wb_done = on_ff && (cnt_ff >= lag);
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the maintenance controller.
// Assumes: One request at a time.
// Notes: The driver queues outcomes and the monitor pops them.
`timescale 1ns/1ps
module testbench;
   import clm_pkg::*;
   logic mclk, srst, req_valid, region_cacheable_bit, prot_viol, fill_busy, wb_done;
   logic busy, done, nop_done, illegal_par, ptr_we;
   logic [PTR_SEL_W-1:0] ptr_wsel;
   logic [ADDR_W-1:0] ptr_val, ptr_wdata;
   logic [3:0] lag;
   clm_req_t req;
   clm_tag_t dtag;
   clm_cmd_t cmd;
   logic [38:0] eq[$];
   logic [34:0] pq[$];
   int n_checks, n_mismatch;
   clm_ctrl dut (
      .mclk(mclk),
      .srst(srst),
      .req_valid(req_valid),
      .req(req),
      .ptr_val(ptr_val),
      .dtag(dtag),
      .region_cacheable_bit(region_cacheable_bit),
      .prot_viol(prot_viol),
      .fill_busy(fill_busy),
      .wb_done(wb_done),
      .busy(busy),
      .done(done),
      .nop_done(nop_done),
      .illegal_par(illegal_par),
      .ptr_we(ptr_we),
      .ptr_wsel(ptr_wsel),
      .ptr_wdata(ptr_wdata),
      .cmd(cmd)
   );
   clm_mem_model mem (.mclk(mclk), .srst(srst), .wr_req(cmd.wrback),
      .wr_ack(cmd.clean | cmd.d_inval), .lag(lag), .wb_done(wb_done));
   always #2 mclk = ~mclk;
   task automatic chk(input string nm, input logic [38:0] e, input logic [38:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One compare task per kind of result; each widens on purpose.
   task automatic chk_outc(input logic [6:0] e, input logic [6:0] g);
      chk("outcome", 39'(e), 39'(g));
   endtask
   task automatic chk_line(input logic [31:0] e, input logic [31:0] g);
      chk("line", 39'(e), 39'(g));
   endtask
   task automatic chk_ptr(input logic [34:0] e, input logic [34:0] g);
      chk("pointer", 39'(e), 39'(g));
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Outcome code: fill, wrback, clean, d_inval, i_inval, no-op, refused; c = {pv,fb,ca,dy,hit}.
   function automatic logic [6:0] outc(input clm_op_t o, input logic [4:0] c);
      if (c[4]) return 7'h20;
      case (o)
         CLM_OP_PREFETCH: return (!c[0] && c[2] && !c[3]) ? 7'h01 : 7'h20;
         CLM_OP_WRBACK: return (c[0] && c[1]) ? 7'h02 : 7'h20;
         CLM_OP_WRBACK_INV: return !c[0] ? 7'h20 : (c[1] ? 7'h02 : 7'h08);
         default: return 7'h10;
      endcase
   endfunction
   // Called just after an edge; drives one request and waits for its end.
   task automatic run(input clm_op_t o, input logic [4:0] c, input logic par);
      logic [6:0] e;
      logic [ADDR_W-1:0] p;
      logic [2:0] s;
      logic pi, fin;
      p = $urandom;
      s = 3'($urandom);
      pi = 1'($urandom);
      e = par ? 7'h40 : outc(o, c);
      eq.push_back({e, p[31:5], 5'h00});
      if (e == 7'h02) eq.push_back({(o == CLM_OP_WRBACK) ? 7'h04 : 7'h08, p[31:5], 5'h00});
      if (pi && !par) pq.push_back({s, p + LINE_STEP});
      req_valid <= 1'b1;
      req <= '{o, s, pi, par};
      ptr_val <= p;
      {prot_viol, fill_busy, region_cacheable_bit} <= c[4:2];
      dtag <= '{c[0], c[1]};
      lag <= 4'(3 + $urandom % 7);
      @(posedge mclk);
      req_valid <= 1'b0;
      fin = 1'b0;
      repeat (40) if (!fin) begin
         @(posedge mclk);
         fin = done | illegal_par;
      end
      if (!fin) chk("completion", 39'h1, 39'h0);
   endtask
   // Registered outputs are read at the edge, before they update.
   always @(posedge mclk) begin
      logic [6:0] ev;
      logic [38:0] x;
      ev = {illegal_par, nop_done, cmd.i_inval, cmd.d_inval, cmd.clean, cmd.wrback, cmd.fill};
      if (!srst && ev !== 7'h00) begin
         x = eq.size() ? eq.pop_front() : '0;
         chk_outc(x[38:32], ev);
         if (ev[4:0] !== 5'h00) chk_line(x[31:0], cmd.line_addr);
      end
      if (!srst && ptr_we !== 1'b0)
         chk_ptr(pq.size() ? pq.pop_front() : '0, {ptr_wsel, ptr_wdata});
   end
   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      {req_valid, req, ptr_val, dtag, region_cacheable_bit, prot_viol, fill_busy, lag} = '0;
      void'($urandom(32'h5CBEC08E));
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      for (int k = 0; k < 128; k++) run(clm_op_t'(k[1:0]), k[6:2], 1'b0);
      for (int k = 0; k < 4; k++) run(clm_op_t'(k[1:0]), 5'h03, 1'b1);
      for (int k = 0; k < 4; k++) run(CLM_OP_WRBACK_INV, 5'h03, 1'b0);
      repeat (4) @(posedge mclk);
      chk("drained", 39'(eq.size() + pq.size()), 39'h0);
      summarize();
   end
   initial begin
      #80000;
      n_mismatch++;
      summarize();
   end
endmodule
